// >>> src/sdt_pkg.sv
package sdt_pkg;
  // ==========================================================
  // widths and fixed codes
  localparam int         ADDR_W     = 16;
  localparam int         DATA_W     = 8;
  localparam int         BUF_DEPTH  = 2;
  localparam logic [2:0] CYC_MIN    = 3'h2;
  localparam logic [2:0] CYC_MAX    = 3'h4;
  localparam logic [7:0] RETI_B0    = 8'hed;
  localparam logic [7:0] RETI_B1    = 8'h4d;
  localparam logic [7:0] PULSE_LAST = 8'hff;
  // ==========================================================
  // status byte bit positions
  localparam int ST_READY = 0;
  localparam int ST_INT   = 1;
  localparam int ST_MATCH = 2;
  localparam int ST_END   = 3;
  // ==========================================================
  // vector modification: cause code replaces bits [2:1]
  localparam int         VEC_LO      = 1;
  localparam logic [1:0] CAUSE_READY = 2'h0;
  localparam logic [1:0] CAUSE_MATCH = 2'h1;
  localparam logic [1:0] CAUSE_END   = 2'h2;
  // ==========================================================
  // early-end bits inside a port config
  localparam int EE_IO  = 0;
  localparam int EE_MEM = 1;
  localparam int EE_RD  = 2;
  localparam int EE_WR  = 3;
  // ==========================================================
  // reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  typedef enum logic [1:0] {OP_XFER = 2'h1, OP_SEARCH = 2'h2, OP_BOTH = 2'h3} sdt_op_t;
  typedef enum logic [1:0] {MD_BYTE = 2'h0, MD_BURST = 2'h1, MD_CONT = 2'h2} sdt_mode_t;
  typedef enum logic [1:0] {AM_FIXED = 2'h0, AM_INC = 2'h1, AM_DEC = 2'h2} sdt_amode_t;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_REQ   = 3'h1,
    S_RD    = 3'h3,
    S_WR    = 3'h2,
    S_PAUSE = 3'h6,
    S_REL   = 3'h4
  } sdt_state_t;

  typedef struct packed {
    logic       is_io;
    sdt_amode_t amode;
    logic [2:0] cyc_len;
    logic [3:0] early;
  } sdt_port_cfg_t;

  typedef struct packed {
    logic rdy_act_low;
    logic auto_restart;
    logic stop_on_match;
    logic ie_ready;
    logic ie_match;
    logic ie_end;
    logic status_vec;
  } sdt_ctrl_t;
endpackage

// >>> src/sdt_dma.sv
`timescale 1ns/1ps
// Notes on behaviour
// - transfer, search, or transfer with search
// - master bus; read source, write destination
// - compare each byte to match under mask
// - byte mode releases buses after each byte
// - burst stops after byte once ready drops
// - continuous pauses holding buses until ready
// - byte once read always completes
// - control writes only when idle; they disable
// - read-status and initial-read commands disable
// - status byte, count and both addresses readable
// - cycle length 2, 3 or 4, waits extend
// - each strobe may end half period early
// - 16-bit addresses fixed, up or down
// - source address on read, destination on write
// - auto restart reloads addresses, clears count
// - start buffers writable without touching counters
// - ready, match, end interrupts set pending, vector
// - end-of-block match reflects previous byte
// - acknowledge puts 8-bit vector on data
// - pulse every 256 bytes, offset first
// - pulses only while request and grant active
// - ready polarity programmable
// - priority out follows priority in unless servicing us
// - drive buses only after grant low
module sdt_dma import sdt_pkg::*; #(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic          REF_CLK,
  input  wire logic          RESET_N,
  input  wire logic          CTRL_WR_STB,
  input  wire logic          CMD_READ_STATUS,
  input  wire logic          CMD_INIT_READ,
  input  wire logic          CMD_ENABLE,
  input  wire logic          CMD_LOAD,
  input  wire logic          CMD_CLEAR_STATUS,
  input  wire sdt_op_t       OP_CLASS,
  input  wire sdt_mode_t     MODE,
  input  wire sdt_port_cfg_t PORT_A_CFG,
  input  wire sdt_port_cfg_t PORT_B_CFG,
  input  wire logic          A_IS_SRC,
  input  wire sdt_ctrl_t     CTRL,
  input  wire logic [15:0]   BLOCK_LEN,
  input  wire logic [7:0]    MATCH_BYTE,
  input  wire logic [7:0]    MATCH_MASK,
  input  wire logic [7:0]    VECTOR_BASE,
  input  wire logic [7:0]    PULSE_OFFSET,
  input  wire logic          START_WR_STB,
  input  wire logic [15:0]   START_A,
  input  wire logic [15:0]   START_B,
  input  wire logic          BUS_GRANT_IN_N,
  input  wire logic          BUS_HOLD_REQUEST_IN_N,
  output logic               BUS_HOLD_REQUEST_OE,
  input  wire logic          RDY,
  input  wire logic          WAIT_N,
  input  wire logic          IO_REQUEST_STROBE_N_I,
  input  wire logic          RD_N_I,
  input  wire logic          M1_N,
  input  wire logic [7:0]    DATA_IN,
  output logic [7:0]         DATA_OUT,
  output logic               DATA_OE,
  output logic [15:0]        ADDR_OUT,
  output logic               ADDR_OE,
  output logic               IO_REQUEST_STROBE_N_O,
  output logic               MEMORY_REQUEST_STROBE_N_O,
  output logic               RD_N_O,
  output logic               WR_N_O,
  output logic               STROBE_OE,
  output logic               INT_N_OE,
  input  wire logic          PRIORITY_ENABLE_IN,
  output logic               PRIORITY_ENABLE_OUT,
  output logic [7:0]         STATUS_BYTE,
  output logic [15:0]        BYTE_COUNT,
  output logic [15:0]        ADDR_A_CUR,
  output logic [15:0]        ADDR_B_CUR,
  output logic               ENABLED
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sdt_dma: DEPTH must be a power of two, at least 2");
  end

  // ==========================================================
  // state
  sdt_state_t  st_q;
  logic        en_q;
  logic [2:0]  ph_q;
  logic [15:0] addr_a_q, addr_b_q, start_a_q, start_b_q, cnt_q;
  logic [7:0]  pulse_q;
  logic        hold_valid_q, hold_match_q;
  logic        p_rdy_q, p_match_q, p_end_q, int_q;
  logic [1:0]  cause_q;
  logic        in_service_q, fetch_q, reti_b0_q;
  logic        bus_hold_request_q, master_q;

  // ==========================================================
  // DEPTH-entry data buffer between read and write phases, two entries by default
  logic [7:0]  mem_q [DEPTH];
  logic [PW:0] wp_q, rp_q;
  logic        in_valid, in_ready, out_valid, out_ready;
  logic [7:0]  out_data;

  // full test needs the pointer width plus one, or depth folds to zero
  assign in_ready  = (wp_q - rp_q) != (PW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[PW-1:0]];

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && in_ready)
        wp_q <= wp_q + 1'b1;
      if (out_valid && out_ready)
        rp_q <= rp_q + 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_buf
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N)
          mem_q[gi] <= BYTE_RST;
        else if (in_valid && in_ready && wp_q[PW-1:0] == PW'(gi))
          mem_q[gi] <= DATA_IN;
      end
    end
  endgenerate

  // ==========================================================
  // cycle timing: one REF_CLK is a half T-cycle
  sdt_port_cfg_t src_cfg, dst_cfg, cur_cfg;
  logic [2:0]    len;
  logic [3:0]    last_ph;
  logic          fin, hold, rdy_act, search, xfer, ctl_ok;

  assign src_cfg = A_IS_SRC ? PORT_A_CFG : PORT_B_CFG;
  assign dst_cfg = A_IS_SRC ? PORT_B_CFG : PORT_A_CFG;
  assign cur_cfg = (st_q == S_WR) ? dst_cfg : src_cfg;
  // out-of-range lengths fall back to the slowest setting
  assign len     = (cur_cfg.cyc_len < CYC_MIN || cur_cfg.cyc_len > CYC_MAX) ?
                   CYC_MAX : cur_cfg.cyc_len;
  assign last_ph = {len, 1'b0} - 4'h1;
  assign hold    = ({1'b0, ph_q} == last_ph - 4'h1) && !WAIT_N;
  assign fin     = (st_q == S_RD || st_q == S_WR) && {1'b0, ph_q} == last_ph;
  assign rdy_act = RDY ^ CTRL.rdy_act_low;
  assign search  = OP_CLASS == OP_SEARCH || OP_CLASS == OP_BOTH;
  assign xfer    = OP_CLASS != OP_SEARCH;
  assign ctl_ok  = !bus_hold_request_q;

  assign in_valid  = st_q == S_RD && fin;
  // search-only has no write phase, so the buffer drains at once
  assign out_ready = xfer ? (st_q == S_WR && fin) : 1'b1;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      ph_q <= 3'h0;
    else if (st_q != S_RD && st_q != S_WR || fin)
      ph_q <= 3'h0;
    else if (!hold)
      ph_q <= ph_q + 3'h1;
  end

  // ==========================================================
  // byte-level sequencing
  logic last_byte, match_ev, byte_done, stop;

  assign last_byte = cnt_q == BLOCK_LEN;
  assign byte_done = fin && (st_q == S_WR || !xfer);
  assign stop      = match_ev && CTRL.stop_on_match;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= S_IDLE;
    end else begin
      case (st_q)
        S_IDLE:
          if (en_q && rdy_act && BUS_HOLD_REQUEST_IN_N)
            st_q <= S_REQ;
        S_REQ:
          if (!BUS_GRANT_IN_N)
            st_q <= S_RD;
        S_RD:
          if (fin)
            st_q <= xfer ? S_WR : S_PAUSE;
        S_WR:
          if (fin)
            st_q <= S_PAUSE;
        S_PAUSE:
          if (!en_q || stop || MODE == MD_BYTE)
            st_q <= S_REL;
          else if (MODE == MD_BURST && !rdy_act)
            st_q <= S_REL;
          else if (rdy_act && in_ready)
            st_q <= S_RD;
        S_REL:
          st_q <= S_IDLE;
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // enable: any control write while idle disables
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      en_q <= 1'b0;
    // a search-only match shows after the byte, so stop is not tied to byte_done
    else if (stop || byte_done && last_byte && !CTRL.auto_restart)
      en_q <= 1'b0;
    else if (ctl_ok && (CTRL_WR_STB || CMD_READ_STATUS || CMD_INIT_READ))
      en_q <= 1'b0;
    else if (ctl_ok && CMD_ENABLE)
      en_q <= 1'b1;
  end

  // ==========================================================
  // address counters and start buffers
  function automatic logic [15:0] step(input logic [15:0] a, input sdt_amode_t m);
    case (m)
      AM_INC:  step = a + 16'h1;
      AM_DEC:  step = a - 16'h1;
      default: step = a;
    endcase
  endfunction

  logic restart;
  assign restart = byte_done && last_byte && CTRL.auto_restart;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      start_a_q <= ADDR_RST;
      start_b_q <= ADDR_RST;
    end else if (START_WR_STB) begin
      start_a_q <= START_A;
      start_b_q <= START_B;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_a_q <= ADDR_RST;
      addr_b_q <= ADDR_RST;
    end else if (restart || ctl_ok && CMD_LOAD) begin
      addr_a_q <= start_a_q;
      addr_b_q <= start_b_q;
    end else if (fin) begin
      if ((st_q == S_RD) == A_IS_SRC)
        addr_a_q <= step(addr_a_q, PORT_A_CFG.amode);
      else
        addr_b_q <= step(addr_b_q, PORT_B_CFG.amode);
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      cnt_q <= ADDR_RST;
    else if (restart || ctl_ok && CMD_LOAD)
      cnt_q <= ADDR_RST;
    else if (byte_done)
      cnt_q <= cnt_q + 16'h1;
  end

  // ==========================================================
  // match: a byte's result is reported when the next is taken
  logic hit;
  assign hit      = ((out_data ^ MATCH_BYTE) & MATCH_MASK) == 8'h00;
  assign match_ev = search && out_valid && out_ready && hold_valid_q && hold_match_q;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_valid_q <= 1'b0;
      hold_match_q <= 1'b0;
    end else if (restart || ctl_ok && CMD_LOAD) begin
      hold_valid_q <= 1'b0;
      hold_match_q <= 1'b0;
    end else if (search && out_valid && out_ready) begin
      hold_valid_q <= 1'b1;
      hold_match_q <= hit;
    end
  end

  // ==========================================================
  // interrupt pending flags; a new event beats a clear
  logic ev_rdy, ev_end, ack;
  assign ev_rdy = st_q == S_IDLE && en_q && rdy_act && BUS_HOLD_REQUEST_IN_N && CTRL.ie_ready;
  assign ev_end = byte_done && last_byte;
  assign ack    = !IO_REQUEST_STROBE_N_I && !M1_N && int_q && PRIORITY_ENABLE_IN && !bus_hold_request_q;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      p_rdy_q   <= 1'b0;
      p_match_q <= 1'b0;
      p_end_q   <= 1'b0;
    end else begin
      p_rdy_q   <= ev_rdy || p_rdy_q && !CMD_CLEAR_STATUS;
      p_match_q <= match_ev || p_match_q && !CMD_CLEAR_STATUS;
      p_end_q   <= ev_end || p_end_q && !CMD_CLEAR_STATUS;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      int_q   <= 1'b0;
      cause_q <= CAUSE_READY;
    end else if (match_ev && CTRL.ie_match) begin
      int_q   <= 1'b1;
      cause_q <= CAUSE_MATCH;
    end else if (ev_end && CTRL.ie_end) begin
      int_q   <= 1'b1;
      cause_q <= CAUSE_END;
    end else if (ev_rdy) begin
      int_q   <= 1'b1;
      cause_q <= CAUSE_READY;
    end else if (CMD_CLEAR_STATUS) begin
      int_q   <= 1'b0;
    end
  end

  // ==========================================================
  // service tracking: ack sets, return-from-interrupt clears
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fetch_q      <= 1'b0;
      reti_b0_q    <= 1'b0;
      in_service_q <= 1'b0;
    end else begin
      fetch_q <= !M1_N && !RD_N_I;
      if (!M1_N && !RD_N_I && !fetch_q) begin
        reti_b0_q <= DATA_IN == RETI_B0;
        if (reti_b0_q && DATA_IN == RETI_B1)
          in_service_q <= 1'b0;
      end
      if (ack)
        in_service_q <= 1'b1;
    end
  end

  // ==========================================================
  // pulse counter
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      pulse_q <= BYTE_RST;
    else if (ctl_ok && CMD_ENABLE)
      pulse_q <= PULSE_OFFSET;
    else if (byte_done)
      pulse_q <= pulse_q + 8'h1;
  end

  // ==========================================================
  // pin registers
  logic [2:0] ph_out;
  logic       early_off, act;
  assign ph_out    = fin ? 3'h0 : (hold ? ph_q : ph_q + 3'h1);
  assign act       = (st_q == S_RD || st_q == S_WR) && !fin;
  assign early_off = {1'b0, ph_out} == last_ph;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_hold_request_q                  <= 1'b0;
      master_q                  <= 1'b0;
      BUS_HOLD_REQUEST_OE       <= 1'b0;
      ADDR_OE                   <= 1'b0;
      STROBE_OE                 <= 1'b0;
      ADDR_OUT                  <= ADDR_RST;
      IO_REQUEST_STROBE_N_O     <= 1'b1;
      MEMORY_REQUEST_STROBE_N_O <= 1'b1;
      RD_N_O                    <= 1'b1;
      WR_N_O                    <= 1'b1;
    end else begin
      bus_hold_request_q            <= st_q != S_IDLE && st_q != S_REL;
      BUS_HOLD_REQUEST_OE <= st_q != S_IDLE && st_q != S_REL;
      master_q            <= st_q != S_IDLE && st_q != S_REL && !BUS_GRANT_IN_N;
      ADDR_OE             <= act || st_q == S_PAUSE;
      STROBE_OE           <= act || st_q == S_PAUSE;
      ADDR_OUT <= ((st_q == S_WR) == A_IS_SRC) ? addr_b_q : addr_a_q;
      IO_REQUEST_STROBE_N_O     <= !(act && cur_cfg.is_io && ph_out != 3'h0 &&
                                     !(cur_cfg.early[EE_IO] && early_off));
      MEMORY_REQUEST_STROBE_N_O <= !(act && !cur_cfg.is_io && ph_out != 3'h0 &&
                                     !(cur_cfg.early[EE_MEM] && early_off));
      RD_N_O <= !(act && st_q == S_RD && ph_out != 3'h0 &&
                  !(cur_cfg.early[EE_RD] && early_off));
      WR_N_O <= !(act && st_q == S_WR && ph_out != 3'h0 &&
                  !(cur_cfg.early[EE_WR] && early_off));
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OE  <= 1'b0;
      DATA_OUT <= BYTE_RST;
    end else if (ack) begin
      DATA_OE  <= 1'b1;
      DATA_OUT <= CTRL.status_vec ?
                  {VECTOR_BASE[7:3], cause_q, VECTOR_BASE[0]} : VECTOR_BASE;
    end else begin
      DATA_OE  <= st_q == S_WR && !fin;
      DATA_OUT <= out_data;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INT_N_OE            <= 1'b0;
      PRIORITY_ENABLE_OUT <= 1'b0;
    end else begin
      // as master the line carries the pulse, so the cpu never sees it
      INT_N_OE <= master_q ? (byte_done && pulse_q == PULSE_LAST)
                           : (int_q && PRIORITY_ENABLE_IN && !in_service_q);
      PRIORITY_ENABLE_OUT <= PRIORITY_ENABLE_IN && !in_service_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      STATUS_BYTE <= BYTE_RST;
      BYTE_COUNT  <= ADDR_RST;
      ADDR_A_CUR  <= ADDR_RST;
      ADDR_B_CUR  <= ADDR_RST;
      ENABLED     <= 1'b0;
    end else begin
      STATUS_BYTE           <= BYTE_RST;
      STATUS_BYTE[ST_READY] <= rdy_act;
      STATUS_BYTE[ST_INT]   <= int_q;
      STATUS_BYTE[ST_MATCH] <= p_match_q;
      STATUS_BYTE[ST_END]   <= p_end_q;
      BYTE_COUNT            <= cnt_q;
      ADDR_A_CUR            <= addr_a_q;
      ADDR_B_CUR            <= addr_b_q;
      ENABLED               <= en_q;
    end
  end
endmodule

// >>> test/sdt_dma_chk.sv
`timescale 1ns/1ps
module sdt_dma_chk (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CTRL_WR_STB,
  input wire logic CMD_READ_STATUS,
  input wire logic CMD_INIT_READ,
  input wire logic CMD_ENABLE,
  input wire logic BUS_GRANT_IN_N,
  input wire logic BUS_HOLD_REQUEST_OE,
  input wire logic RD_N_O,
  input wire logic WR_N_O,
  input wire logic STROBE_OE,
  input wire logic DATA_OE,
  input wire logic ADDR_OE,
  input wire logic INT_N_OE,
  input wire logic PRIORITY_ENABLE_IN,
  input wire logic PRIORITY_ENABLE_OUT,
  input wire logic ENABLED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  logic dis_cmd;
  assign dis_cmd = CTRL_WR_STB | CMD_READ_STATUS | CMD_INIT_READ;
  // ==========================================================
  // bus ownership
  a_drive_granted: assert property ($rose(STROBE_OE) |-> !BUS_GRANT_IN_N)
    else $error("strobes driven without grant");
  a_strobe_owner: assert property (STROBE_OE |-> BUS_HOLD_REQUEST_OE)
    else $error("strobes driven without request");
  a_release_float: assert property ($fell(BUS_HOLD_REQUEST_OE)
    |-> !ADDR_OE && !STROBE_OE)
    else $error("outputs still driven after release");
  a_read_no_drive: assert property (STROBE_OE && !RD_N_O |-> !DATA_OE)
    else $error("data driven during read");
  a_write_data: assert property (STROBE_OE && !WR_N_O |-> DATA_OE)
    else $error("write without data");
  // ==========================================================
  // commands and chain
  a_prio_chain: assert property (!PRIORITY_ENABLE_IN && !$past(PRIORITY_ENABLE_IN)
    |-> !PRIORITY_ENABLE_OUT)
    else $error("priority out high with input low");
  a_ctrl_disable: assert property (dis_cmd && !CMD_ENABLE && !BUS_HOLD_REQUEST_OE
    |-> ##2 !ENABLED)
    else $error("control write did not disable");
  a_enable_cmd: assert property (CMD_ENABLE && !dis_cmd && !BUS_HOLD_REQUEST_OE
    |-> ##2 ENABLED)
    else $error("enable command ignored");
  c_tenure: cover property ($rose(STROBE_OE));
  c_pulse: cover property (INT_N_OE && BUS_HOLD_REQUEST_OE);
  c_disabled: cover property ($fell(ENABLED));
endmodule
bind sdt_dma sdt_dma_chk chk_u (.*);

// >>> test/sdt_mem_model.sv
`timescale 1ns/1ps
module sdt_mem_model (
  input  wire logic        clk,
  input  wire logic        req_oe,
  input  wire logic        soe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             grant_n,
  output logic             req_in_n,
  output logic             wait_n,
  output logic [7:0]       rdata
);
  logic [7:0] mem [256];
  logic [1:0] gcnt = 2'h0;
  logic       rd_q = 1'b0;
  logic [7:0] a_q = 8'h00;
  wire        rd = soe && !rd_n;
  initial grant_n = 1'b1;
  // pull-up on the shared request line
  assign req_in_n = !req_oe;
  assign wait_n = 1'b1;
  // data held one clock past the strobe, then flipped so a late capture shows
  assign rdata = rd ? mem[addr[7:0]] : rd_q ? mem[a_q] : ~mem[a_q];
  always @(posedge clk) begin
    gcnt <= req_oe ? gcnt + 2'(gcnt != 2'h3) : 2'h0;
    grant_n <= !(req_oe && gcnt == 2'h3);
    rd_q <= rd;
    if (rd) a_q <= addr[7:0];
    if (soe && !wr_n) mem[addr[7:0]] <= wdata;
  end
endmodule

// >>> test/tb_single_channel_dma_transfer_search.sv
`timescale 1ns/1ps
module tb_single_channel_dma_transfer_search import sdt_pkg::*; ;
  logic clk = 0, rst_n = 0, rdy = 0, prio_in = 1, a_src = 1, req_q = 0;
  logic ack_n = 1, mq = 0, iq = 0, int_oe, memory_request_strobe_o, io_o;
  logic [6:0] cs = '0;
  sdt_op_t op = OP_XFER;
  sdt_mode_t md = MD_BYTE;
  sdt_port_cfg_t pa = '0, pb = '0;
  sdt_ctrl_t ctl = '0;
  logic [15:0] blen = '0, sta = 16'h0010, stb = '0, aout, bc, aa, ab;
  logic [7:0] mbyte = '0, mmask = '0, din, dout, stat;
  logic grant_n, req_in_n, wait_n, reqoe, aoe, rd_o, wr_o, soe, prio_out, en;
  int err_count = 0, samples_checked = 0, n_req = 0, cnt_rd = 0, rd_len = 0;
  int rl [3];
  always #5 clk = ~clk;
  sdt_mem_model mem_u (.clk(clk), .req_oe(reqoe), .soe(soe), .rd_n(rd_o), .wr_n(wr_o),
    .addr(aout), .wdata(dout), .grant_n(grant_n), .req_in_n(req_in_n), .wait_n(wait_n),
    .rdata(din));
  sdt_dma dut_u (
    .REF_CLK(clk), .RESET_N(rst_n), .CTRL_WR_STB(cs[0]), .CMD_READ_STATUS(cs[1]),
    .CMD_INIT_READ(cs[2]), .CMD_ENABLE(cs[3]), .CMD_LOAD(cs[4]), .CMD_CLEAR_STATUS(cs[5]),
    .OP_CLASS(op), .MODE(md), .PORT_A_CFG(pa), .PORT_B_CFG(pb), .A_IS_SRC(a_src), .CTRL(ctl),
    .BLOCK_LEN(blen), .MATCH_BYTE(mbyte), .MATCH_MASK(mmask), .VECTOR_BASE(8'h40),
    .PULSE_OFFSET(8'h01), .START_WR_STB(cs[6]), .START_A(sta), .START_B(stb),
    .BUS_GRANT_IN_N(grant_n), .BUS_HOLD_REQUEST_IN_N(req_in_n), .BUS_HOLD_REQUEST_OE(reqoe),
    .RDY(rdy), .WAIT_N(wait_n), .IO_REQUEST_STROBE_N_I(ack_n), .RD_N_I(1'b1), .M1_N(ack_n),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(), .ADDR_OUT(aout), .ADDR_OE(aoe),
    .IO_REQUEST_STROBE_N_O(io_o), .MEMORY_REQUEST_STROBE_N_O(memory_request_strobe_o),
    .RD_N_O(rd_o), .WR_N_O(wr_o),
    .STROBE_OE(soe), .INT_N_OE(int_oe), .PRIORITY_ENABLE_IN(prio_in),
    .PRIORITY_ENABLE_OUT(prio_out), .STATUS_BYTE(stat), .BYTE_COUNT(bc), .ADDR_A_CUR(aa),
    .ADDR_B_CUR(ab), .ENABLED(en));
  // ==========================================================
  // bus tenures and read strobe length
  always @(posedge clk) begin
    req_q <= reqoe;
    if (reqoe && !req_q) n_req <= n_req + 1;
    if (soe && !memory_request_strobe_o) mq <= 1'b1;
    if (soe && !io_o) iq <= 1'b1;
    if (soe && !rd_o) cnt_rd <= cnt_rd + 1;
    else if (cnt_rd != 0) begin
      rd_len <= cnt_rd;
      cnt_rd <= 0;
    end
  end
  // ==========================================================
  // tasks
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bit k of cs: wr, rd status, init read, enable, load, clear, start buffers
  task cmd(input int k);
    cs = 7'h01 << k;
    cyc(1);
    cs = '0;
    cyc(1);
  endtask
  // kind 1 waits for the address bus, kind 0 for a finished, released run
  task waitf(input bit kind);
    int i;
    for (i = 0; i < 3000; i++) begin
      if (kind ? aoe === 1'b1 : (!reqoe && (stat[ST_END] || stat[ST_MATCH]))) break;
      cyc(1);
    end
    if (i == 3000) begin
      err_count++;
      end_sim;
    end
  endtask
  function automatic sdt_port_cfg_t mkp(input sdt_amode_t am, input logic [2:0] l,
                                        input logic [3:0] ee);
    mkp = '{is_io: 1'b0, amode: am, cyc_len: l, early: ee};
  endfunction
  task start(input sdt_mode_t m, input sdt_op_t o, input sdt_port_cfg_t b,
             input logic [15:0] sb);
    md = m;
    op = o;
    pb = b;
    stb = sb;
    n_req = 0;
    cmd(6);
    cmd(4);
    cmd(5);
    cmd(3);
    rdy = 1;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int m, i;
    logic [7:0] d;
    for (i = 0; i < 256; i++) mem_u.mem[i] = i[7:0] ^ 8'h5a;
    ctl.ie_end = 1;
    ctl.ie_match = 1;
    blen = 16'h0003;
    cyc(16);
    rst_n = 1;
    cyc(2);
    for (m = 0; m < 3; m++) begin
      pa = mkp(AM_INC, 3'h2 + m[2:0], m == 2 ? 4'h4 : 4'h0);
      for (i = 0; i < 24; i++) mem_u.mem[8'h78 + i] = 8'h00;
      start(sdt_mode_t'(m), OP_XFER, mkp(m == 0 ? AM_DEC : m == 1 ? AM_INC : AM_FIXED,
            3'h2, 4'h0), m == 0 ? 16'h008f : 16'h0080);
      if (m > 0) begin
        waitf(1);
        rdy = 0;
        cyc(30);
        chk("bus held", 16'(m == 2), 16'(reqoe));
        rdy = 1;
      end
      waitf(0);
      for (i = 0; i < 4; i++) begin
        d = m == 0 ? 8'h8f - i[7:0] : m == 1 ? 8'h80 + i[7:0] : 8'h80;
        if (m < 2 || i == 3) chk("dest", 16'((8'h10 + i[7:0]) ^ 8'h5a), 16'(mem_u.mem[d]));
      end
      chk("tenures", m == 0 ? 16'h4 : m == 1 ? 16'h2 : 16'h1, 16'(n_req));
      chk("count", 16'h0004, bc);
      chk("addr a", 16'h0014, aa);
      chk("addr b", m == 0 ? 16'h008b : m == 1 ? 16'h0084 : 16'h0080, ab);
      cyc(2);
      chk("int", 16'h1, 16'(int_oe));
      rl[m] = rd_len;
      $display("test transfer mode %0d done", m);
    end
    chk("rd len 3", 16'(rl[0] + 2), 16'(rl[1]));
    chk("rd len 4 early", 16'(rl[0] + 3), 16'(rl[2]));
    chk("mem strobe", 16'h1, 16'(mq));
    chk("io strobe", 16'h0, 16'(iq));
    mbyte = 8'h08;
    mmask = 8'h0f;
    ctl.stop_on_match = 1;
    blen = 16'h0007;
    start(MD_CONT, OP_SEARCH, pb, 16'h0080);
    waitf(0);
    chk("match", 16'h1, 16'(stat[ST_MATCH]));
    chk("end", 16'h0, 16'(stat[ST_END]));
    chk("stopped", 16'h0, 16'(en));
    chk("search count", 16'h0004, bc);
    ctl.status_vec = 1;
    ack_n = 0;
    cyc(1);
    chk("vector", 16'h0042, 16'(dout));
    ack_n = 1;
    cyc(1);
    chk("prio serviced", 16'h0, 16'(prio_out));
    $display("test search done");
    rdy = 0;
    for (i = 0; i < 3; i++) begin
      cmd(3);
      cyc(2);
      chk("enable", 16'h1, 16'(en));
      cmd(i);
      cyc(2);
      chk("disable", 16'h0, 16'(en));
    end
    prio_in = 0;
    cyc(2);
    chk("prio out", 16'h0, 16'(prio_out));
    prio_in = 1;
    $display("test commands done");
    end_sim;
  end
endmodule
